// [verif/tb.sv]
// Purpose: self-checking bench for the configuration register bank
// Assumes: one-cycle byte requests, answers exactly one cycle later
// Notes:   watchdog shortened to 50 cycles so a timeout fits the run
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int         WDT = 50;
    localparam logic [7:0] AB  = tsc_pkg::ADDR_CTRL_AB;
    localparam logic [7:0] CD  = tsc_pkg::ADDR_CTRL_CD;
    logic              mclk_i   = 1'b0;
    logic              resetn_i = 1'b0;
    tsc_pkg::tsc_req_t req      = '0;
    logic              pad_ev   = 1'b0;
    logic [7:0]        pad_in   = 8'h00;
    logic              win_end  = 1'b0;
    logic [7:0]        ev_in    = 8'h00;
    logic [7:0]        rdata, pad_flags, ev_out;
    logic              ack, refused, tune, rt_acc, rs_acc, rt_cmd, rs_cmd;
    logic              show_rst, wdt_rst, pad_tick, prox_tick;
    tsc_pkg::tsc_cfg_t cfg;
    int                bad_count = 0;
    int                n_tests = 0;
    int                cyc = 0, wdt_n = 0, pad_n = 0;
    int                pad_cnt = 0, prox_cnt = 0, pad_gap = 0, prox_gap = 0;

    always #4 mclk_i = ~mclk_i;

    tsc_config_regs #(.WDT_CYCLES(WDT)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .req_i(req), .rdata_o(rdata), .ack_o(ack), .refused_o(refused),
        .tuning_active_i(tune), .retune_accept_i(rt_acc), .reseed_accept_i(rs_acc),
        .retune_cmd_o(rt_cmd), .reseed_cmd_o(rs_cmd), .show_reset_o(show_rst),
        .wdt_reset_o(wdt_rst), .pad_event_i(pad_ev), .pad_flags_in_i(pad_in),
        .comm_window_end_i(win_end), .pad_flags_o(pad_flags), .events_i(ev_in),
        .events_o(ev_out), .cfg_o(cfg), .pad_charge_tick_o(pad_tick),
        .prox_charge_tick_o(prox_tick));

    tsc_core_model core (.mclk_i(mclk_i), .resetn_i(resetn_i), .retune_cmd_i(rt_cmd),
        .reseed_cmd_i(rs_cmd), .retune_accept_o(rt_acc), .reseed_accept_o(rs_acc),
        .tuning_active_o(tune));

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // cycle budget, watchdog pulses and spacing between charge ticks
    always @(posedge mclk_i) begin
        cyc++;
        pad_cnt++;
        prox_cnt++;
        if (wdt_rst === 1'b1) wdt_n++;
        if (pad_tick === 1'b1) begin
            pad_gap = pad_cnt;
            pad_cnt = 0;
            pad_n++;
        end
        if (prox_tick === 1'b1) begin
            prox_gap = prox_cnt;
            prox_cnt = 0;
        end
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic exp, input logic got);
        chk8(nm, {7'h00, exp}, {7'h00, got});
    endtask : chk1

    // one request for one cycle; answer looked at one cycle later
    task automatic access(input logic [7:0] a, input logic o, input logic w,
                          input logic [7:0] d);
        @(posedge mclk_i);
        req <= '{addr: a, offs: o, wr: w, rd: !w, wdata: d};
        @(posedge mclk_i);
        req <= '0;
        #1;
    endtask : access

    task automatic wr(input logic [7:0] a, input logic o, input logic [7:0] d);
        access(a, o, 1'b1, d);
        chk1("ack", 1'b1, ack);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic o, input logic [7:0] exp);
        access(a, o, 1'b0, 8'h00);
        chk1("ack", 1'b1, ack);
        chk8("rdata", exp, rdata);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : idle

    // end of communication window as a one-cycle pulse
    task automatic win();
        @(posedge mclk_i);
        win_end <= 1'b1;
        @(posedge mclk_i);
        win_end <= 1'b0;
        #1;
    endtask : win

    initial begin
        int k;
        logic [7:0] v;
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        #1;
        rd(AB, 1'b0, 8'h00);
        rd(AB, 1'b1, 8'h11);
        rd(CD, 1'b0, 8'h03);
        rd(CD, 1'b1, 8'h00);
        rd(tsc_pkg::ADDR_MASK, 1'b0, 8'hbf);
        rd(8'h90, 1'b0, 8'h00);
        chk1("show_reset", 1'b1, show_rst);
        chk8("lta_shift", 8'h08, {4'h0, cfg.lta_shift});
        chk8("seg_rate", 8'h08, cfg.segment_rate);
        // writable bits only; mask writes are ignored
        wr(AB, 1'b0, 8'he4);
        rd(AB, 1'b0, 8'he4);
        wr(AB, 1'b1, 8'hff);
        rd(AB, 1'b1, 8'hf3);
        wr(CD, 1'b0, 8'hff);
        rd(CD, 1'b0, 8'h37);
        wr(CD, 1'b1, 8'h7f);
        rd(CD, 1'b1, 8'h7f);
        wr(tsc_pkg::ADDR_MASK, 1'b0, 8'h00);
        rd(tsc_pkg::ADDR_MASK, 1'b0, 8'hbf);
        wr(CD, 1'b1, 8'h80);
        chk1("show_reset", 1'b0, show_rst);
        rd(CD, 1'b1, 8'h00);
        // watchdog on: one timeout in the idle stretch, then off: none
        wr(AB, 1'b1, 8'h11);
        wdt_n = 0;
        idle(WDT + 10);
        chk8("wdt_pulses", 8'h01, wdt_n[7:0]);
        chk1("show_reset", 1'b1, show_rst);
        wr(AB, 1'b1, 8'h91);
        wdt_n = 0;
        idle(3 * WDT);
        chk8("wdt_pulses", 8'h00, wdt_n[7:0]);
        for (k = 0; k < 2; k++) begin
            v = (k == 0) ? 8'he7 : 8'h00;
            wr(AB, 1'b0, v);
            chk8("cfg_a", {3'h0, v[7], v[6], v[5], v[1], v[0]}, {3'h0,
                 cfg.auto_tuning_disable, cfg.partial_tuning, cfg.tuning_band_wide,
                 cfg.long_settling, cfg.force_halt});
        end
        for (k = 0; k < 4; k++) begin
            wr(AB, 1'b1, 8'h80 | 8'(k << 4) | 8'(k) | (k[0] ? 8'h40 : 8'h00));
            chk8("lta_shift", 8'(9 - k), {4'h0, cfg.lta_shift});
            chk8("acf", {5'h0, k != 0, 2'(k)},
                 {5'h0, cfg.ac_filter_en, cfg.ac_filter_coef});
            chk1("event_mode", k[0], cfg.event_mode);
        end
        for (k = 0; k < 8; k++) begin
            wr(CD, 1'b0, {2'h0, k[0], 2'h0, 3'(k)});
            chk8("seg_rate", 8'h01 << k, cfg.segment_rate);
            chk1("wake_both", k[0], cfg.wake_both_dir);
        end
        for (k = 0; k < 2; k++) begin
            v = (k == 0) ? 8'h7c : 8'h00;
            wr(CD, 1'b1, v);
            chk8("cfg_d", {3'h0, v[6:2]}, {3'h0, cfg.off_mode, cfg.projected_bias_boost,
                 cfg.float_sense_pins, cfg.halt_charge,
                 cfg.distributed_proximity});
        end
        chk1("show_reset", 1'b1, show_rst);
        // retune pends, then tuning refuses access while bit 2 is clear
        wr(AB, 1'b0, 8'h10);
        chk1("retune_cmd", 1'b1, rt_cmd);
        rd(AB, 1'b0, 8'h10);
        for (k = 0; k < 100 && rt_cmd !== 1'b0; k++) idle(1);
        access(AB, 1'b0, 1'b0, 8'h00);
        chk1("refused", 1'b1, refused);
        chk1("ack", 1'b0, ack);
        access(CD, 1'b0, 1'b1, 8'h05);
        chk1("refused", 1'b1, refused);
        for (k = 0; k < 100 && tune !== 1'b0; k++) idle(1);
        rd(CD, 1'b0, 8'h27);
        rd(AB, 1'b0, 8'h00);
        wr(AB, 1'b0, 8'h0c);
        chk1("reseed_cmd", 1'b1, rs_cmd);
        for (k = 0; k < 100 && rs_cmd !== 1'b0; k++) idle(1);
        rd(AB, 1'b0, 8'h04);
        wr(AB, 1'b0, 8'h14);
        for (k = 0; k < 100 && rt_cmd !== 1'b0; k++) idle(1);
        wr(CD, 1'b0, 8'h05);
        rd(CD, 1'b0, 8'h05);
        wr(AB, 1'b0, 8'h04);
        chk1("retune_cmd", 1'b0, rt_cmd);
        // flags held over a window, cleared once auto clear is on
        @(posedge mclk_i);
        pad_in <= 8'h5a;
        pad_ev <= 1'b1;
        ev_in  <= 8'ha5;
        @(posedge mclk_i);
        pad_ev <= 1'b0;
        win();
        chk8("pad_flags", 8'h5a, pad_flags);
        chk8("events", 8'ha5, ev_out);
        wr(CD, 1'b0, 8'h15);
        win();
        chk8("pad_flags", 8'h00, pad_flags);
        // charge tick spacing, normal then slow, then none when halted or in off mode
        idle(600);
        chk8("pad_gap", tsc_pkg::DIV_PAD_FAST, pad_gap[7:0]);
        chk8("prox_gap", tsc_pkg::DIV_PROX_FAST, prox_gap[7:0]);
        wr(CD, 1'b1, 8'h03);
        idle(600);
        chk8("pad_gap", tsc_pkg::DIV_PAD_SLOW, pad_gap[7:0]);
        chk8("prox_gap", tsc_pkg::DIV_PROX_SLOW, prox_gap[7:0]);
        for (k = 0; k < 2; k++) begin
            wr(CD, 1'b1, (k == 0) ? 8'h08 : 8'h40);
            idle(10);
            v = 8'(pad_n);
            idle(300);
            chk8("pad_ticks", v, 8'(pad_n));
        end
        conclude();
    end
endmodule : tb
`default_nettype wire

// [verif/tsc_core_model.sv]
// Purpose: sensing core stand-in that takes retune and reseed commands
// Assumes: commands are levels held by the bank until the accept pulse
// Notes:   accepts late on purpose so a pending command can be read back
`timescale 1ns/1ps
`default_nettype none
module tsc_core_model #(
    parameter int DELAY    = 6,
    parameter int TUNE_LEN = 20
) (
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    input  wire logic retune_cmd_i,
    input  wire logic reseed_cmd_i,
    output logic      retune_accept_o,
    output logic      reseed_accept_o,
    output logic      tuning_active_o
);
    logic [7:0] rt_q;
    logic [7:0] rs_q;
    logic [7:0] tune_q;
    // waits before taking a command; a retune then keeps tuning busy
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rt_q            <= 8'h00;
            rs_q            <= 8'h00;
            tune_q          <= 8'h00;
            retune_accept_o <= 1'b0;
            reseed_accept_o <= 1'b0;
        end else begin
            retune_accept_o <= 1'b0;
            reseed_accept_o <= 1'b0;
            if (tune_q != 8'h00) tune_q <= tune_q - 8'h01;
            // guard on the accept so one command is taken only once
            if (retune_cmd_i && !retune_accept_o) rt_q <= rt_q + 8'h01;
            if (retune_cmd_i && !retune_accept_o && rt_q == 8'(DELAY)) begin
                rt_q            <= 8'h00;
                retune_accept_o <= 1'b1;
                tune_q          <= 8'(TUNE_LEN);
            end
            if (reseed_cmd_i && !reseed_accept_o) rs_q <= rs_q + 8'h01;
            if (reseed_cmd_i && !reseed_accept_o && rs_q == 8'(DELAY)) begin
                rs_q            <= 8'h00;
                reseed_accept_o <= 1'b1;
            end
        end
    end
    assign tuning_active_o = (tune_q != 8'h00);
endmodule : tsc_core_model
`default_nettype wire

// [verilog/tsc_config_regs.sv]
// Purpose: configuration and event-mask register bank of the trackpad sensing controller
// Assumes: requests come decoded from the serial port logic on the same clock
// Notes:   one request per cycle at most; answers follow one cycle later
`timescale 1ns/1ps
`default_nettype none
module tsc_config_regs #(
    parameter longint WDT_CYCLES = tsc_pkg::WDT_CYCLES
) (
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    input  wire tsc_pkg::tsc_req_t req_i,
    output logic [7:0]             rdata_o,
    output logic                   ack_o,
    output logic                   refused_o,
    input  wire logic              tuning_active_i,
    input  wire logic              retune_accept_i,
    input  wire logic              reseed_accept_i,
    output logic                   retune_cmd_o,
    output logic                   reseed_cmd_o,
    output logic                   show_reset_o,
    output logic                   wdt_reset_o,
    input  wire logic              pad_event_i,
    input  wire logic [7:0]        pad_flags_in_i,
    input  wire logic              comm_window_end_i,
    output logic [7:0]             pad_flags_o,
    input  wire logic [7:0]        events_i,
    output logic [7:0]             events_o,
    output tsc_pkg::tsc_cfg_t      cfg_o,
    output logic                   pad_charge_tick_o,
    output logic                   prox_charge_tick_o
);
    logic [7:0]  ctrl_a_q;
    logic [7:0]  ctrl_b_q;
    logic [7:0]  ctrl_c_q;
    logic [7:0]  ctrl_d_q;
    logic        retune_q;
    logic        reseed_q;
    logic        show_reset_q;
    logic [31:0] wdt_cnt_q;
    logic        wdt_fire;
    logic        access;
    logic        take;
    logic        wr_a;
    logic        wr_b;
    logic        wr_c;
    logic        wr_d;
    logic [7:0]  rd_d;
    logic        charge_en;
    logic [7:0]  pad_div;
    logic [7:0]  prox_div;

    // refuse everything while tuning runs unless the host asked to talk through it
    assign access = req_i.wr || req_i.rd;
    assign take   = access
                    && !(tuning_active_i && !ctrl_a_q[tsc_pkg::A_COMMS_TUNE]);
    assign wr_a   = take && req_i.wr && req_i.addr == tsc_pkg::ADDR_CTRL_AB
                    && req_i.offs == tsc_pkg::OFFS_LO;
    assign wr_b   = take && req_i.wr && req_i.addr == tsc_pkg::ADDR_CTRL_AB
                    && req_i.offs == tsc_pkg::OFFS_HI;
    assign wr_c   = take && req_i.wr && req_i.addr == tsc_pkg::ADDR_CTRL_CD
                    && req_i.offs == tsc_pkg::OFFS_LO;
    assign wr_d   = take && req_i.wr && req_i.addr == tsc_pkg::ADDR_CTRL_CD
                    && req_i.offs == tsc_pkg::OFFS_HI;

    // plain control bytes; command bits are kept apart below
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            ctrl_a_q <= tsc_pkg::RST_CTRL_A;
            ctrl_b_q <= tsc_pkg::RST_CTRL_B;
            ctrl_c_q <= tsc_pkg::RST_CTRL_C;
            ctrl_d_q <= tsc_pkg::RST_CTRL_D;
        end else begin
            if (wr_a) ctrl_a_q <= req_i.wdata & tsc_pkg::WMASK_CTRL_A;
            if (wr_b) ctrl_b_q <= req_i.wdata & tsc_pkg::WMASK_CTRL_B;
            if (wr_c) ctrl_c_q <= req_i.wdata & tsc_pkg::WMASK_CTRL_C;
            if (wr_d) ctrl_d_q <= req_i.wdata & tsc_pkg::WMASK_CTRL_D;
        end
    end

    // command bits: a write of one wins over the core's accept in the same cycle
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            retune_q <= 1'b0;
            reseed_q <= 1'b0;
        end else begin
            if (wr_a && req_i.wdata[tsc_pkg::A_RETUNE]) begin
                retune_q <= 1'b1;
            end else if (retune_accept_i) begin
                retune_q <= 1'b0;
            end
            if (wr_a && req_i.wdata[tsc_pkg::A_RESEED]) begin
                reseed_q <= 1'b1;
            end else if (reseed_accept_i) begin
                reseed_q <= 1'b0;
            end
        end
    end

    // reset indication: set by every reset and by a watchdog reset, set wins
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            show_reset_q <= 1'b1;
        end else if (wdt_fire) begin
            show_reset_q <= 1'b1;
        end else if (wr_d && req_i.wdata[tsc_pkg::D_ACK_RESET]) begin
            show_reset_q <= 1'b0;
        end
    end

    // watchdog restarts on every accepted access; counts even when disabled
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || take || wdt_cnt_q >= 32'(WDT_CYCLES - 1)) begin
            wdt_cnt_q <= 32'h0000_0000;
        end else begin
            wdt_cnt_q <= wdt_cnt_q + 32'h0000_0001;
        end
    end
    assign wdt_fire    = !take && wdt_cnt_q >= 32'(WDT_CYCLES - 1)
                         && !ctrl_b_q[tsc_pkg::B_WDT_OFF];
    assign wdt_reset_o = wdt_fire;

    // read mux; acknowledge bit always reads zero since it acts at once
    always_comb begin
        rd_d = 8'h00;
        if (req_i.addr == tsc_pkg::ADDR_CTRL_AB && req_i.offs == tsc_pkg::OFFS_LO) begin
            rd_d = ctrl_a_q;
            rd_d[tsc_pkg::A_RETUNE] = retune_q;
            rd_d[tsc_pkg::A_RESEED] = reseed_q;
        end else if (req_i.addr == tsc_pkg::ADDR_CTRL_AB) begin
            rd_d = ctrl_b_q;
        end else if (req_i.addr == tsc_pkg::ADDR_CTRL_CD
                     && req_i.offs == tsc_pkg::OFFS_LO) begin
            rd_d = ctrl_c_q;
        end else if (req_i.addr == tsc_pkg::ADDR_CTRL_CD) begin
            rd_d = ctrl_d_q;
        end else if (req_i.addr == tsc_pkg::ADDR_MASK && req_i.offs == tsc_pkg::OFFS_LO) begin
            rd_d = tsc_pkg::RST_EVENT_MASK & tsc_pkg::RMASK_EVENT;
        end
    end

    // answer one cycle after the request; unmapped reads return zero
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rdata_o   <= 8'h00;
            ack_o     <= 1'b0;
            refused_o <= 1'b0;
        end else begin
            ack_o     <= take;
            refused_o <= access && !take;
            if (take && req_i.rd) rdata_o <= rd_d;
        end
    end

    // trackpad flags: latest event, optionally wiped when the window closes
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            pad_flags_o <= 8'h00;
        end else if (pad_event_i) begin
            pad_flags_o <= pad_flags_in_i;
        end else if (comm_window_end_i && ctrl_c_q[tsc_pkg::C_AUTO_CLEAR]) begin
            pad_flags_o <= 8'h00;
        end
    end

    // the mask is fixed to all-enabled except bit 6, which RMASK_EVENT blocks, so it costs no storage
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            events_o <= 8'h00;
        end else begin
            events_o <= events_i & tsc_pkg::RST_EVENT_MASK & tsc_pkg::RMASK_EVENT;
        end
    end

    // decoded configuration, straight from the flops
    always_comb begin
        cfg_o.auto_tuning_disable   = ctrl_a_q[tsc_pkg::A_TUNE_OFF];
        cfg_o.partial_tuning        = ctrl_a_q[tsc_pkg::A_PARTIAL];
        cfg_o.tuning_band_wide      = ctrl_a_q[tsc_pkg::A_BAND];
        cfg_o.long_settling         = ctrl_a_q[tsc_pkg::A_SETTLE];
        cfg_o.force_halt            = ctrl_a_q[tsc_pkg::A_HALT];
        cfg_o.event_mode            = ctrl_b_q[tsc_pkg::B_EVENT_MODE];
        cfg_o.lta_shift             = tsc_pkg::LTA_SHIFT_BASE
                                      - {2'b00, ctrl_b_q[tsc_pkg::B_LTA_MSB:tsc_pkg::B_LTA_LSB]};
        cfg_o.ac_filter_en          = |ctrl_b_q[tsc_pkg::B_ACF_MSB:tsc_pkg::B_ACF_LSB];
        cfg_o.ac_filter_coef        = ctrl_b_q[tsc_pkg::B_ACF_MSB:tsc_pkg::B_ACF_LSB];
        cfg_o.wake_both_dir         = ctrl_c_q[tsc_pkg::C_WAKE_BOTH];
        cfg_o.segment_rate          = 8'h01 << ctrl_c_q[tsc_pkg::C_RATE_MSB:tsc_pkg::C_RATE_LSB];
        cfg_o.off_mode              = ctrl_d_q[tsc_pkg::D_OFF_MODE];
        cfg_o.halt_charge           = ctrl_d_q[tsc_pkg::D_HALT_CHG];
        cfg_o.float_sense_pins      = ctrl_d_q[tsc_pkg::D_FLOAT];
        cfg_o.distributed_proximity = ctrl_d_q[tsc_pkg::D_DIST];
        cfg_o.projected_bias_boost  = ctrl_d_q[tsc_pkg::D_BIAS];
    end

    assign retune_cmd_o = retune_q;
    assign reseed_cmd_o = reseed_q;
    assign show_reset_o = show_reset_q;

    // charge rate enables; halted or off means no charge pulses at all
    assign charge_en = !ctrl_d_q[tsc_pkg::D_HALT_CHG] && !ctrl_d_q[tsc_pkg::D_OFF_MODE];
    assign pad_div   = ctrl_d_q[tsc_pkg::D_SLOW_PAD] ? tsc_pkg::DIV_PAD_SLOW
                                                     : tsc_pkg::DIV_PAD_FAST;
    assign prox_div  = ctrl_d_q[tsc_pkg::D_SLOW_PROX] ? tsc_pkg::DIV_PROX_SLOW
                                                      : tsc_pkg::DIV_PROX_FAST;

    tsc_rate_div u_pad_div (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .en_i     (charge_en),
        .div_i    (pad_div),
        .tick_o   (pad_charge_tick_o)
    );

    tsc_rate_div u_prox_div (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .en_i     (charge_en),
        .div_i    (prox_div),
        .tick_o   (prox_charge_tick_o)
    );

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    refuse_tuning_a: assert property (
        access && tuning_active_i && !ctrl_a_q[tsc_pkg::A_COMMS_TUNE]
        |=> refused_o && !ack_o)
        else $error("access during tuning was not refused");

    retune_set_a: assert property (
        wr_a && req_i.wdata[tsc_pkg::A_RETUNE] |=> retune_cmd_o)
        else $error("retune write did not raise the command");

    retune_clear_a: assert property (
        retune_accept_i && !(wr_a && req_i.wdata[tsc_pkg::A_RETUNE])
        |=> !retune_cmd_o)
        else $error("retune command did not clear on accept");

    reseed_zero_a: assert property (
        wr_a && !req_i.wdata[tsc_pkg::A_RESEED] && !reseed_cmd_o |=> !reseed_cmd_o)
        else $error("writing zero started a reseed");

    ack_reset_a: assert property (
        wr_d && req_i.wdata[tsc_pkg::D_ACK_RESET] && !wdt_fire |=> !show_reset_o)
        else $error("reset acknowledge did not clear the indication");

    wdt_off_a: assert property (
        ctrl_b_q[tsc_pkg::B_WDT_OFF] |-> !wdt_reset_o)
        else $error("watchdog reset while disabled");

    wdt_fire_a: assert property (
        wdt_reset_o |=> show_reset_o && wdt_cnt_q == 32'h0000_0000)
        else $error("watchdog reset left no indication");

    seg_rate_a: assert property (
        $countones(cfg_o.segment_rate) == 1
        && cfg_o.segment_rate[ctrl_c_q[tsc_pkg::C_RATE_MSB:tsc_pkg::C_RATE_LSB]])
        else $error("segment rate is not a power of two of the field");

    lta_shift_a: assert property (
        cfg_o.lta_shift >= 4'h6 && cfg_o.lta_shift <= 4'h9)
        else $error("average coefficient out of range");

    pad_clear_a: assert property (
        comm_window_end_i && !pad_event_i && ctrl_c_q[tsc_pkg::C_AUTO_CLEAR]
        |=> pad_flags_o == 8'h00)
        else $error("pad flags survived the window end");

    halt_charge_a: assert property (
        !charge_en [*2] |-> !pad_charge_tick_o && !prox_charge_tick_o)
        else $error("charge pulse while halted");

    pad_fast_a: assert property (
        pad_charge_tick_o && charge_en && !ctrl_d_q[tsc_pkg::D_SLOW_PAD]
        && $stable(ctrl_d_q) |=> !pad_charge_tick_o [*8])
        else $error("pad charge pulses too close");

    mask_pass_a: assert property (
        events_i[0] |=> events_o[0])
        else $error("enabled event was suppressed");

    cover_refuse_c:  cover property (refused_o);
    cover_retune_c:  cover property (retune_cmd_o ##1 !retune_cmd_o);
    cover_wdt_c:     cover property (wdt_reset_o);
    cover_ack_c:     cover property (show_reset_o ##1 !show_reset_o);
endmodule : tsc_config_regs
`default_nettype wire

// [verilog/tsc_pkg.sv]
// Purpose: shared constants and carrier types of the touch sensor configuration bank
// Assumes: 125 MHz device clock, byte-wide register access with address and offset
// Notes:   every address, field position, reset value and cycle count lives here
`default_nettype none
package tsc_pkg;

    // register addresses, two bytes per control address chosen by the offset bit, one low byte at the mask address
    localparam logic [7:0] ADDR_CTRL_AB   = 8'h80;
    localparam logic [7:0] ADDR_CTRL_CD   = 8'h81;
    localparam logic [7:0] ADDR_MASK      = 8'h82;
    localparam logic       OFFS_LO        = 1'b0;
    localparam logic       OFFS_HI        = 1'b1;

    // reset values
    localparam logic [7:0] RST_CTRL_A     = 8'h00;
    localparam logic [7:0] RST_CTRL_B     = 8'h11;
    localparam logic [7:0] RST_CTRL_C     = 8'h03;
    localparam logic [7:0] RST_CTRL_D     = 8'h00;
    localparam logic [7:0] RST_EVENT_MASK = 8'hff;

    // writable bits of each control byte, the rest read as zero except the retune and reseed bits of byte a
    localparam logic [7:0] WMASK_CTRL_A   = 8'he7;
    localparam logic [7:0] WMASK_CTRL_B   = 8'hf3;
    localparam logic [7:0] WMASK_CTRL_C   = 8'h37;
    localparam logic [7:0] WMASK_CTRL_D   = 8'h7f;
    localparam logic [7:0] RMASK_EVENT    = 8'hbf;

    // control byte a fields
    localparam int A_TUNE_OFF   = 7;
    localparam int A_PARTIAL    = 6;
    localparam int A_BAND       = 5;
    localparam int A_RETUNE     = 4;
    localparam int A_RESEED     = 3;
    localparam int A_COMMS_TUNE = 2;
    localparam int A_SETTLE     = 1;
    localparam int A_HALT       = 0;
    // control byte b fields
    localparam int B_WDT_OFF    = 7;
    localparam int B_EVENT_MODE = 6;
    localparam int B_LTA_MSB    = 5;
    localparam int B_LTA_LSB    = 4;
    localparam int B_ACF_MSB    = 1;
    localparam int B_ACF_LSB    = 0;
    // control byte c fields
    localparam int C_WAKE_BOTH  = 5;
    localparam int C_AUTO_CLEAR = 4;
    localparam int C_RATE_MSB   = 2;
    localparam int C_RATE_LSB   = 0;
    // control byte d fields
    localparam int D_ACK_RESET  = 7;
    localparam int D_OFF_MODE   = 6;
    localparam int D_BIAS       = 5;
    localparam int D_FLOAT      = 4;
    localparam int D_HALT_CHG   = 3;
    localparam int D_DIST       = 2;
    localparam int D_SLOW_PAD   = 1;
    localparam int D_SLOW_PROX  = 0;

    // long-term average coefficient 1/512 is a shift of nine
    localparam logic [3:0] LTA_SHIFT_BASE = 4'h9;

    // clock and charge rates
    localparam longint CLK_HZ       = 125_000_000;
    localparam longint PAD_FAST_HZ  = 2_000_000;
    localparam longint PAD_SLOW_HZ  = 1_000_000;
    localparam longint PROX_FAST_HZ = 1_000_000;
    localparam longint PROX_SLOW_HZ = 500_000;
    // a frequency is a longest period, so the divider rounds down
    localparam logic [7:0] DIV_PAD_FAST  = 8'(CLK_HZ / PAD_FAST_HZ);
    localparam logic [7:0] DIV_PAD_SLOW  = 8'(CLK_HZ / PAD_SLOW_HZ);
    localparam logic [7:0] DIV_PROX_FAST = 8'(CLK_HZ / PROX_FAST_HZ);
    localparam logic [7:0] DIV_PROX_SLOW = 8'(CLK_HZ / PROX_SLOW_HZ);

    // communication watchdog window
    localparam longint WDT_TIME_MS  = 10;
    localparam longint WDT_CYCLES   = CLK_HZ / 1000 * WDT_TIME_MS;

    // one register access as handed over by the serial port logic
    typedef struct packed {
        logic [7:0] addr;
        logic       offs;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } tsc_req_t;

    // decoded configuration driven to the sensing core
    typedef struct packed {
        logic       auto_tuning_disable;
        logic       partial_tuning;
        logic       tuning_band_wide;
        logic       long_settling;
        logic       force_halt;
        logic       event_mode;
        logic [3:0] lta_shift;
        logic       ac_filter_en;
        logic [1:0] ac_filter_coef;
        logic       wake_both_dir;
        logic [7:0] segment_rate;
        logic       off_mode;
        logic       halt_charge;
        logic       float_sense_pins;
        logic       distributed_proximity;
        logic       projected_bias_boost;
    } tsc_cfg_t;

endpackage : tsc_pkg
`default_nettype wire

// [verilog/tsc_rate_div.sv]
// Purpose: one-cycle enable pulse every div_i clock cycles
// Assumes: div_i of two or more; a change takes effect at once on the running count
// Notes:   held at zero while disabled so each restart begins a full period
`timescale 1ns/1ps
`default_nettype none
module tsc_rate_div (
    input  wire logic       mclk_i,
    input  wire logic       resetn_i,
    input  wire logic       en_i,
    input  wire logic [7:0] div_i,
    output logic            tick_o
);
    logic [7:0] cnt_q;

    // count up to div_i minus one, then wrap
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || !en_i) begin
            cnt_q <= 8'h00;
        end else if (cnt_q >= div_i - 8'h01) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign tick_o = en_i && (cnt_q >= div_i - 8'h01);
endmodule : tsc_rate_div
`default_nettype wire
